//--- hdl/bss_sequencer.v
// Start-up sequencing and protection latch of a synchronous buck controller.
// Summary of operation
// R1: Start only when supply above 4.3 V and enable pin released.
// R2: Calibration phase keeps both gate drives off.
// R3: Soft-start enables switching and ramps the reference up to 800 mV.
// R4: Calibration lasts 5.5 ms, soft-start ramp lasts 3.5 ms.
// R5: Overcurrent armed once soft-start begun and ramp exceeds pre-biased sense.
// R6: Overvoltage armed 64 switching periods after enable pin above 0.8 V.
// R7: At soft-start end arm undervoltage and raise power good together.
// R8: Sample overcurrent at switching period end while low side on.
// R9: Digitise threshold pin during calibration and latch it as overcurrent reference.
// R10: Overcurrent over two consecutive periods latches both drives off until supply cycles; code latches on the third consecutive sample.
// R11: Threshold pin above 0.5 V holds the device in calibration forever; code leaves the hold for off when the enable pin drops.
// R12: Sense below 600 mV after undervoltage armed latches both drives off.
// R13: Sense above 1 V: high off, low on until 400 mV, then latch off.
// R14: After undervoltage or overvoltage latch, only supply cycling restores operation.
// R15: Power good drops beyond 10% deviation and returns within 6%.
// R16: Power good is open-drain pull-down only; external pull-up required.
// R17: Switching clock fixed at 300 kHz or 600 kHz per variant.
// R18: Enable pin held below 800 mV shuts the device down.
// R19: Persistence and arming counts use switching-clock periods.
`timescale 1ns/1ns
`default_nettype none
`include "bss_defines.vh"
module bss_sequencer #(
   parameter        FAST_VARIANT = 0,
   parameter [31:0] CAL_CYCLES   = `BSS_CAL_CYCLES,
   parameter [31:0] SS_CYCLES    = `BSS_SS_CYCLES
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   input  wire [13:0] supply_mv,
   input  wire [9:0]  comp_enable_mv,
   input  wire [9:0]  low_drive_threshold_pin,
   input  wire [10:0] protection_sense_input,
   input  wire [10:0] feedback_input,
   input  wire        low_side_oc_trip,
   output reg         high_side_drive,
   output reg         low_side_drive,
   output reg         threshold_source_en,
   output reg  [9:0]  oc_reference,
   output reg  [9:0]  reference_mv,
   output reg         power_good_out,
   output reg         power_good_oe_n,
   output reg         oc_armed,
   output reg         ov_armed,
   output reg         uv_armed,
   output reg         latched_off,
   output reg  [2:0]  seq_state
);
   ////////////////////////////////////////////////////////////////////////////
   // Timing and threshold constants, each cut on purpose to the width it meets.
   localparam integer DIV_I       = FAST_VARIANT ? `BSS_DIV_600K : `BSS_DIV_300K;
   localparam integer HALF_I      = DIV_I / 2;
   localparam integer VIN_MIN_I   = `BSS_VIN_MIN_MV;
   localparam integer EN_I        = `BSS_EN_MV;
   localparam integer CAL_MAX_I   = `BSS_CAL_MAX_MV;
   localparam integer UV_I        = `BSS_UV_MV;
   localparam integer OV_I        = `BSS_OV_MV;
   localparam integer OVL_I       = `BSS_OVL_MV;
   localparam integer REF_I       = `BSS_REF_MV;
   localparam integer PG_OUT_LO_I = `BSS_REF_MV - (`BSS_REF_MV * `BSS_PG_OUT_PCT) / 100;
   localparam integer PG_OUT_HI_I = `BSS_REF_MV + (`BSS_REF_MV * `BSS_PG_OUT_PCT) / 100;
   localparam integer PG_IN_LO_I  = `BSS_REF_MV - (`BSS_REF_MV * `BSS_PG_IN_PCT) / 100;
   localparam integer PG_IN_HI_I  = `BSS_REF_MV + (`BSS_REF_MV * `BSS_PG_IN_PCT) / 100;
   localparam integer OV_ARM_I    = `BSS_OV_ARM_PERIODS;
   localparam integer OC_PER_I    = `BSS_OC_PERSIST;

   localparam [9:0]  DIV       = DIV_I[9:0];
   localparam [9:0]  HALF      = HALF_I[9:0];
   localparam [13:0] VIN_MIN   = VIN_MIN_I[13:0];
   localparam [9:0]  EN_MV     = EN_I[9:0];
   localparam [9:0]  CAL_MAX   = CAL_MAX_I[9:0];
   localparam [10:0] UV_MV     = UV_I[10:0];
   localparam [10:0] OV_MV     = OV_I[10:0];
   localparam [10:0] OVL_MV    = OVL_I[10:0];
   localparam [9:0]  REF_MV    = REF_I[9:0];
   localparam [10:0] PG_OUT_LO = PG_OUT_LO_I[10:0];
   localparam [10:0] PG_OUT_HI = PG_OUT_HI_I[10:0];
   localparam [10:0] PG_IN_LO  = PG_IN_LO_I[10:0];
   localparam [10:0] PG_IN_HI  = PG_IN_HI_I[10:0];
   localparam [6:0]  OV_ARM    = OV_ARM_I[6:0];
   localparam [1:0]  OC_PER    = OC_PER_I[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // All analog comparator results and pins arrive asynchronously.
   wire [13:0] sup_s;
   wire [9:0]  en_s;
   wire [9:0]  thr_s;
   wire [10:0] vos_s;
   wire [10:0] fb_s;
   wire        oc_s;
   bss_sync #(.W(57)) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({supply_mv, comp_enable_mv, low_drive_threshold_pin,
              protection_sense_input, feedback_input, low_side_oc_trip}),
      .q   ({sup_s, en_s, thr_s, vos_s, fb_s, oc_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fixed switching clock, one tick per switching period.
   reg  [9:0] sw_cnt_q;
   wire       sw_tick = (sw_cnt_q == DIV - 10'h001);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_cnt_q <= 10'h000;
      end else if (ce) begin
         sw_cnt_q <= sw_tick ? 10'h000 : sw_cnt_q + 10'h001; // see R17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state and the shared phase timer.
   wire supply_ok = (sup_s > VIN_MIN);
   wire enabled   = (en_s >= EN_MV);
   reg  [31:0] tmr_q;
   reg  [6:0]  ov_cnt_q;
   reg  [1:0]  oc_cnt_q;
   reg  [2:0]  st_q;
   reg  [2:0]  st_d;
   wire        cal_end  = (st_q == `BSS_ST_CAL) && (tmr_q == CAL_CYCLES - 32'h1);
   wire        ss_end   = (st_q == `BSS_ST_SS) && (tmr_q == SS_CYCLES - 32'h1);
   wire        oc_fault = oc_armed && sw_tick && low_side_drive && oc_s;

   ////////////////////////////////////////////////////////////////////////////
   // Soft-start ramp: the elapsed share of the ramp time scaled to the target.
   wire [63:0] ramp_num = {32'h0, tmr_q} * {54'h0, REF_MV};
   wire [63:0] ramp_quo = ramp_num / {32'h0, SS_CYCLES};
   wire [9:0]  ramp     = ramp_quo[9:0];

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      st_d = st_q;
      case (st_q)
         `BSS_ST_OFF: begin
            if (supply_ok && enabled) begin
               st_d = `BSS_ST_CAL; // see R1
            end
         end
         `BSS_ST_CAL: begin
            if (!enabled) begin
               st_d = `BSS_ST_OFF; // see R18
            end else if (cal_end) begin
               if (thr_s > CAL_MAX) begin
                  st_d = `BSS_ST_CALHOLD; // see R11
               end else begin
                  st_d = `BSS_ST_SS;
               end
            end
         end
         `BSS_ST_CALHOLD: begin
            if (!enabled) begin
               st_d = `BSS_ST_OFF; // see R11
            end
         end
         `BSS_ST_SS, `BSS_ST_RUN: begin
            if (!enabled) begin
               st_d = `BSS_ST_OFF; // see R18
            end else if (ov_armed && vos_s > OV_MV) begin
               st_d = `BSS_ST_OVDRAIN; // see R13
            end else if (uv_armed && vos_s < UV_MV) begin
               st_d = `BSS_ST_LATCH; // see R12
            end else if (oc_fault && oc_cnt_q == OC_PER) begin
               st_d = `BSS_ST_LATCH; // see R10
            end else if (ss_end) begin
               st_d = `BSS_ST_RUN; // see R4
            end
         end
         `BSS_ST_OVDRAIN: begin
            if (vos_s <= OVL_MV) begin
               st_d = `BSS_ST_LATCH; // see R13
            end
         end
         `BSS_ST_LATCH: st_d = `BSS_ST_LATCH; // see R14
         default: st_d = `BSS_ST_LATCH;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register and phase timer; the timer restarts at every change of state.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q  <= `BSS_ST_OFF;
         tmr_q <= 32'h0;
      end else if (ce) begin
         st_q  <= st_d;
         tmr_q <= (st_d != st_q) ? 32'h0 : tmr_q + 32'h1; // see R4
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Threshold code taken on the last calibration cycle, kept until the last cycle of the next calibration.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_reference <= 10'h000;
      end else if (ce && cal_end) begin
         oc_reference <= thr_s; // see R9
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overvoltage arming counts switching periods while the enable pin is high.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ov_cnt_q <= 7'h00;
         ov_armed <= 1'b0;
      end else if (ce) begin
         if (st_d == `BSS_ST_OFF || st_d == `BSS_ST_CALHOLD) begin
            ov_cnt_q <= 7'h00;
            ov_armed <= 1'b0;
         end else if (enabled && sw_tick && !ov_armed) begin
            ov_cnt_q <= ov_cnt_q + 7'h01;
            if (ov_cnt_q == OV_ARM - 7'h01) ov_armed <= 1'b1; // see R6 R19
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overcurrent arms once the ramp passes the pre-biased sense level.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_armed <= 1'b0;
         uv_armed <= 1'b0;
      end else if (ce) begin
         if (st_q == `BSS_ST_SS && st_d == `BSS_ST_SS && !oc_armed && {1'b0, ramp} > vos_s) begin
            oc_armed <= 1'b1; // see R5
         end else if (st_d == `BSS_ST_OFF) begin
            oc_armed <= 1'b0;
         end
         if (st_q == `BSS_ST_SS && st_d == `BSS_ST_RUN) begin
            uv_armed <= 1'b1; // see R7
         end else if (st_d == `BSS_ST_OFF) begin
            uv_armed <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Consecutive overcurrent samples, taken at the end of each switching period.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_cnt_q <= 2'h0;
      end else if (ce && sw_tick && low_side_drive) begin
         if (oc_s && oc_armed) begin
            if (oc_cnt_q != OC_PER) oc_cnt_q <= oc_cnt_q + 2'h1; // see R8 R10
         end else begin
            oc_cnt_q <= 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-good window with hysteresis; it holds its level between the two bands.
   reg  pg_q;
   reg  pg_d;
   wire fb_out = (fb_s < PG_OUT_LO) || (fb_s > PG_OUT_HI);
   wire fb_in  = (fb_s >= PG_IN_LO) && (fb_s <= PG_IN_HI);
   always @* begin
      pg_d = pg_q;
      if (st_d == `BSS_ST_RUN && st_q == `BSS_ST_SS) begin
         pg_d = 1'b1; // see R7
      end else if (st_d != `BSS_ST_RUN) begin
         pg_d = 1'b0;
      end else if (fb_out) begin
         pg_d = 1'b0; // see R15
      end else if (fb_in) begin
         pg_d = 1'b1; // see R15
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next drive levels and reference; drives stay off outside soft-start, run and overvoltage drain.
   reg       hs_d;
   reg       ls_d;
   reg [9:0] ref_d;
   wire      sw_on_half = (sw_cnt_q < HALF);
   always @* begin
      hs_d  = 1'b0;
      ls_d  = 1'b0;
      ref_d = 10'h000;
      case (st_d)
         `BSS_ST_SS: begin
            ref_d = (st_q == `BSS_ST_SS) ? ramp : 10'h000; // see R3
            hs_d  = sw_on_half;
            ls_d  = !sw_on_half;
         end
         `BSS_ST_RUN: begin
            ref_d = REF_MV; // see R3
            hs_d  = sw_on_half;
            ls_d  = !sw_on_half;
         end
         `BSS_ST_OVDRAIN: begin
            hs_d = 1'b0; // see R13
            ls_d = 1'b1; // see R13
         end
         default: begin
            hs_d = 1'b0; // see R2 R10 R12
            ls_d = 1'b0; // see R2 R10 R12
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate drives and reference, registered so the pins never glitch.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         high_side_drive <= 1'b0;
         low_side_drive  <= 1'b0;
         reference_mv    <= 10'h000;
      end else if (ce) begin
         high_side_drive <= hs_d;
         low_side_drive  <= ls_d;
         reference_mv    <= ref_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer status seen from outside.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         threshold_source_en <= 1'b0;
         latched_off         <= 1'b0;
         seq_state           <= `BSS_ST_OFF;
      end else if (ce) begin
         threshold_source_en <= (st_d == `BSS_ST_CAL); // see R9
         latched_off         <= (st_d == `BSS_ST_LATCH) || (st_d == `BSS_ST_OVDRAIN);
         seq_state           <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain power good: the data bit is always low and only the enable moves.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_q            <= 1'b0;
         power_good_out  <= 1'b0;
         power_good_oe_n <= 1'b1;
      end else if (ce) begin
         pg_q            <= pg_d;
         power_good_out  <= 1'b0; // see R16
         power_good_oe_n <= pg_d; // see R15 R16
      end
   end
endmodule // bss_sequencer
`default_nettype wire

//--- hdl/bss_defines.vh
// Constants for the buck start-up and fault sequencer.
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH
`define BSS_CLK_HZ          100000000
`define BSS_CAL_TIME_US     5500
`define BSS_SS_TIME_US      3500
`define BSS_CAL_CYCLES      ((`BSS_CLK_HZ / 1000000) * `BSS_CAL_TIME_US)
`define BSS_SS_CYCLES       ((`BSS_CLK_HZ / 1000000) * `BSS_SS_TIME_US)
`define BSS_FSW_300K_HZ     300000
`define BSS_FSW_600K_HZ     600000
`define BSS_DIV_300K        (`BSS_CLK_HZ / `BSS_FSW_300K_HZ)
`define BSS_DIV_600K        (`BSS_CLK_HZ / `BSS_FSW_600K_HZ)
`define BSS_OV_ARM_PERIODS  64
`define BSS_OC_PERSIST      2
`define BSS_REF_MV          800
`define BSS_VIN_MIN_MV      4300
`define BSS_EN_MV           800
`define BSS_CAL_MAX_MV      500
`define BSS_UV_MV           600
`define BSS_OV_MV           1000
`define BSS_OVL_MV          400
`define BSS_PG_OUT_PCT      10
`define BSS_PG_IN_PCT       6
`define BSS_ST_OFF          3'h0
`define BSS_ST_CAL          3'h1
`define BSS_ST_SS           3'h2
`define BSS_ST_RUN          3'h3
`define BSS_ST_OVDRAIN      3'h4
`define BSS_ST_LATCH        3'h5
`define BSS_ST_CALHOLD      3'h6
`endif

//--- hdl/bss_sync.v
// Two-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module bss_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         ce,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // bss_sync
`default_nettype wire

//--- verif/bss_sequencer_properties.sv
// Concurrent checks on the ports of the start-up and fault sequencer.
`timescale 1ns/1ns
`default_nettype none
module bss_sequencer_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       high_side_drive,
   input wire logic       low_side_drive,
   input wire logic [9:0] reference_mv,
   input wire logic       power_good_out,
   input wire logic       power_good_oe_n,
   input wire logic       oc_armed,
   input wire logic       uv_armed,
   input wire logic [2:0] seq_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_cal_off; seq_state == 3'h1 |-> !high_side_drive && !low_side_drive; endproperty
   a_cal_off: assert property (p_cal_off) else $error("drive on in calibration");
   property p_hold_off; seq_state == 3'h6 |-> !high_side_drive && !low_side_drive; endproperty
   a_hold_off: assert property (p_hold_off) else $error("drive on in hold");
   property p_ref; seq_state == 3'h3 |-> reference_mv == 10'h320; endproperty
   a_ref: assert property (p_ref) else $error("reference not at target");
   property p_run_uv; seq_state == 3'h3 && $past(seq_state) == 3'h2 |-> uv_armed && power_good_oe_n;
   endproperty
   a_run_uv: assert property (p_run_uv) else $error("uv or good late");
   property p_od; power_good_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("good pin driven high");
   property p_oc; $rose(oc_armed) |-> seq_state == 3'h2; endproperty
   a_oc: assert property (p_oc) else $error("oc armed outside ramp");
   property p_ovd; seq_state == 3'h4 |-> !high_side_drive && low_side_drive; endproperty
   a_ovd: assert property (p_ovd) else $error("drain drives wrong");
   property p_latch;
      seq_state == 3'h5 |=> seq_state == 3'h5 && !high_side_drive && !low_side_drive;
   endproperty
   a_latch: assert property (p_latch) else $error("latch left or drive on");
   c_run: cover property (seq_state == 3'h3);
   c_latch: cover property (seq_state == 3'h5);
   c_hold: cover property (seq_state == 3'h6);
endmodule // bss_sequencer_props
bind bss_sequencer bss_sequencer_props bss_sequencer_props_i (
   .clk(clk), .rst(rst), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
   .reference_mv(reference_mv), .power_good_out(power_good_out),
   .power_good_oe_n(power_good_oe_n), .oc_armed(oc_armed), .uv_armed(uv_armed),
   .seq_state(seq_state));
`default_nettype wire

//--- verif/bss_far_side.sv
// Model of the system enable logic and the low-side current comparator.
`timescale 1ns/1ns
`default_nettype none
module bss_far_side (
   input  wire logic       low_side_drive,
   input  wire logic       en_pull_low,
   input  wire logic       over_current,
   output var  logic       low_side_oc_trip,
   output var  logic [9:0] comp_enable_mv
);
   // Open-drain enable: once released the pin rises above the shutdown level.
   always_comb comp_enable_mv = en_pull_low ? 10'h000 : 10'h384;
   // The valley current is only seen while the low-side switch conducts.
   always_comb low_side_oc_trip = over_current && low_side_drive;
endmodule // bss_far_side
`default_nettype wire

//--- verif/bss_sequencer_tb_top.sv
// Self-checking bench for the buck start-up and fault sequencer.
`timescale 1ns/1ns
`default_nettype none
module bss_sequencer_tb_top;
   localparam int CAL = 200;
   localparam int SS  = 100;
   logic        clk, rst, ce, en_low, oc, trip, hs, ls, tse, pgo, pg_n, oca, ova, uva, lat;
   logic [13:0] sup;
   logic [9:0]  thr, cen, ocr, ref_mv;
   logic [10:0] sense, fb;
   logic [2:0]  st;
   int          errors, checked, n;
   bss_far_side bss_far_side_i (.low_side_drive(ls), .en_pull_low(en_low), .over_current(oc),
      .low_side_oc_trip(trip), .comp_enable_mv(cen));
   bss_sequencer #(.FAST_VARIANT(1), .CAL_CYCLES(CAL), .SS_CYCLES(SS)) bss_sequencer_i (
      .clk(clk), .rst(rst), .ce(ce), .supply_mv(sup), .comp_enable_mv(cen),
      .low_drive_threshold_pin(thr), .protection_sense_input(sense), .feedback_input(fb),
      .low_side_oc_trip(trip), .high_side_drive(hs), .low_side_drive(ls),
      .threshold_source_en(tse), .oc_reference(ocr), .reference_mv(ref_mv),
      .power_good_out(pgo), .power_good_oe_n(pg_n), .oc_armed(oca), .ov_armed(ova),
      .uv_armed(uva), .latched_off(lat), .seq_state(st));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input logic [2:0] s, input int lim);
      n = 0;
      while (st !== s && n < lim) begin
         tick(1);
         n++;
      end
   endtask
   // Reset with supply held at 4.4 V, then enable release with the given threshold pin level.
   task automatic power_up(input logic [9:0] t);
      rst = 1'b1;
      ce = 1'b1;
      en_low = 1'b1;
      oc = 1'b0;
      thr = t;
      // Pre-biased output below target, so the ramp has to pass it.
      sense = 11'h258;
      fb = 11'h320;
      sup = 14'h1130;
      tick(4);
      chk("rst_drive", {hs, ls, pg_n}, 3'h1);
      rst = 1'b0;
      tick(6);
      chk("held_off", st, 3'h0);
      en_low = 1'b0;
      wait_st(3'h1, 10);
      chk("src_en", tse, 1'b1);
   endtask
   task automatic to_run(input logic [9:0] t);
      wait_st(3'h2, CAL + 5);
      chk("cal_len", 11'(n), 11'(CAL));
      chk("oc_code", ocr, t);
      chk("ov_early", ova, 1'b0);
      wait_st(3'h3, SS + 5);
      chk("ss_len", 11'(n), 11'(SS));
      chk("uv_good", {uva, pg_n, oca}, 3'h7);
      chk("ref_run", ref_mv, 11'h320);
      n = 0;
      while (ova !== 1'b1 && n < 12000) begin
         tick(1);
         n++;
      end
      chk("ov_arm", ova, 1'b1);
   endtask
   initial begin
      errors = 0;
      checked = 0;
      power_up(10'h12C);
      to_run(10'h12C);
      fb = 11'h384;
      tick(6);
      chk("pg_out", pg_n, 1'b0);
      fb = 11'h33E;
      tick(6);
      chk("pg_back", pg_n, 1'b1);
      ce = 1'b0;
      sense = 11'h1F4;
      tick(10);
      chk("ce_freeze", st, 3'h3);
      ce = 1'b1;
      wait_st(3'h5, 10);
      chk("uv_latch", {st, hs, ls}, 5'h14);
      chk("uv_latched", lat, 1'b1);
      sense = 11'h320;
      en_low = 1'b1;
      tick(10);
      chk("latch_hold", st, 3'h5);
      power_up(10'h258);
      wait_st(3'h6, CAL + 5);
      tick(50);
      chk("cal_hold", st, 3'h6);
      power_up(10'h12C);
      to_run(10'h12C);
      sense = 11'h44C;
      wait_st(3'h4, 10);
      chk("ov_drain", {hs, ls}, 2'h1);
      sense = 11'h186;
      wait_st(3'h5, 10);
      chk("ov_latch", st, 3'h5);
      power_up(10'h12C);
      to_run(10'h12C);
      oc = 1'b1;
      wait_st(3'h5, 1000);
      chk("oc_latch", {st, hs, ls}, 5'h14);
      test_done;
   end
   initial begin
      #1000000;
      errors++;
      test_done;
   end
endmodule // bss_sequencer_tb_top
`default_nettype wire
